// [rtl/pwm_gen_c_reload_timing.v]
// generator c timing and reload control: prescaler, counter, modulus, load frequency,
// reload flag and deadtime, with an avalon-mm register slave
// assumes one core clock, synchronous unit-level inputs, and software as only partner
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "pwm_c_regs.vh"
module pwm_gen_c_reload_timing
(
   input  wire        core_clk_in,
   input  wire        arst_n_in,
   input  wire [4:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output reg  [31:0] avs_readdata_out,
   output wire        avs_waitrequest_out,
   input  wire        multi_generator_enable_in,
   input  wire        write_protect_in,
   input  wire        global_load_okay_in,
   input  wire        center_aligned_in,
   output wire        reload_irq_out,
   output wire        reload_pulse_out,
   output reg  [14:0] counter_out,
   output reg  [11:0] deadtime_ticks_out,
   output wire [1:0]  prescaler_active_out,
   output wire [14:0] modulus_active_out
);
   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   reg  [3:0]  ldfq_buf_r;
   reg  [3:0]  ldfq_act_r;
   reg         half_r;
   reg  [1:0]  prsc_buf_r;
   reg  [1:0]  prsc_act_r;
   reg         flag_r;
   reg         flag_armed_r;
   reg  [14:0] mod_buf_r;
   reg  [14:0] mod_act_r;
   reg  [11:0] dtm_r;
   reg         ldok_r;
   reg         ldok_armed_r;
   reg         gsel_r;
   reg         irq_en_r;
   reg  [3:0]  opp_cnt_r;
   reg         count_down_r;
   reg         ack_r;
   reg  [14:0] counter_nxt;
   reg         down_nxt;

   wire        tick;
   wire        opportunity;
   wire        reload;
   wire        load_ok;
   wire        wr_acc;
   wire        rd_acc;
   wire        wr_fq;
   wire        wr_mod;
   wire        wr_dtm;
   wire        wr_en;
   wire        wr_lo_lane;
   wire        wr_hi_lane;

   // ---------------------------------------------------------------
   // bus slave: one wait cycle, then answer
   // ---------------------------------------------------------------
   // waitrequest drops one cycle after the request rises, so every access
   // takes two edges; it keeps read data registered off the bus path
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
   assign wr_acc     = avs_write_in & ~avs_waitrequest_out;
   assign rd_acc     = avs_read_in & ~avs_waitrequest_out;
   assign wr_lo_lane = avs_byteenable_in[0];
   assign wr_hi_lane = avs_byteenable_in[1];

   function hit;
      input [4:0] addr;
      input [4:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   assign wr_fq  = wr_acc & multi_generator_enable_in & hit(avs_address_in, `OFS_FREQ_CTRL);
   assign wr_mod = wr_acc & multi_generator_enable_in & hit(avs_address_in, `OFS_MODULUS);
   assign wr_dtm = wr_acc & multi_generator_enable_in & ~write_protect_in
                   & hit(avs_address_in, `OFS_DEADTIME);
   assign wr_en  = wr_acc & multi_generator_enable_in & hit(avs_address_in, `OFS_ENABLE_CTRL);

   always @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         ack_r <= 1'b0;
      else
         ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
   end

   // ---------------------------------------------------------------
   // reload timing
   // ---------------------------------------------------------------
   assign load_ok = gsel_r ? global_load_okay_in : ldok_r;

   pwm_c_prescaler u_prescaler
   (
      .core_clk_in (core_clk_in),
      .arst_n_in   (arst_n_in),
      .restart_in  (reload),
      .sel_in      (prsc_act_r),
      .tick_out    (tick)
   );

   // opportunity at count zero, or at modulus match when half-cycle reload is on
   assign opportunity = tick & (
                        (counter_out == `MOD_ZERO) ? ~count_down_r :
                        (half_r & center_aligned_in & (counter_out == mod_act_r) &
                         ~count_down_r));
   assign reload      = opportunity & (opp_cnt_r == ldfq_act_r);

   always @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         opp_cnt_r <= 4'h0;
      else if (reload)
         opp_cnt_r <= 4'h0;
      else if (opportunity)
         opp_cnt_r <= opp_cnt_r + 4'h1;
   end

   // counter runs up to modulus-1 (edge) or up to modulus then down (center)
   always @*
   begin
      counter_nxt = counter_out;
      down_nxt    = count_down_r;
      if (tick)
      begin
         if (center_aligned_in)
         begin
            if (!count_down_r && counter_out >= mod_act_r)
            begin
               down_nxt    = 1'b1;
               counter_nxt = counter_out - `MOD_ONE;
            end
            else if (count_down_r && counter_out <= `MOD_ONE)
            begin
               down_nxt    = 1'b0;
               counter_nxt = `MOD_ZERO;
            end
            else if (count_down_r)
               counter_nxt = counter_out - `MOD_ONE;
            else
               counter_nxt = counter_out + `MOD_ONE;
         end
         else
         begin
            down_nxt    = 1'b0;
            // period equals modulus pwm clocks
            if (counter_out >= mod_act_r - `MOD_ONE)
               counter_nxt = `MOD_ZERO;
            else
               counter_nxt = counter_out + `MOD_ONE;
         end
      end
   end

   always @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         counter_out  <= `MOD_ZERO;
         count_down_r <= 1'b0;
      end
      else
      begin
         counter_out  <= counter_nxt;
         count_down_r <= down_nxt;
      end
   end

   // load frequency moves into use at every reload, prescaler and modulus only at a reload with load okay
   always @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ldfq_act_r <= 4'h0;
         prsc_act_r <= 2'h0;
         mod_act_r  <= `RST_MODULUS;
      end
      else if (reload)
      begin
         ldfq_act_r <= ldfq_buf_r;
         if (load_ok)
         begin
            prsc_act_r <= prsc_buf_r;
            mod_act_r  <= mod_buf_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // software-written fields
   // ---------------------------------------------------------------
   always @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ldfq_buf_r <= 4'h0;
         half_r     <= 1'b0;
         prsc_buf_r <= 2'h0;
         mod_buf_r  <= `RST_MODULUS;
         dtm_r      <= `RST_DEADTIME;
         gsel_r     <= 1'b0;
         irq_en_r   <= 1'b0;
      end
      else
      begin
         if (wr_fq && wr_lo_lane)
         begin
            ldfq_buf_r <= avs_writedata_in[`FQ_LDFQ_HI:`FQ_LDFQ_LO];
            half_r     <= avs_writedata_in[`FQ_HALF_BIT];
            prsc_buf_r <= avs_writedata_in[`FQ_PRSC_HI:`FQ_PRSC_LO];
         end
         if (wr_mod && wr_lo_lane)
            mod_buf_r[7:0] <= avs_writedata_in[7:0];
         if (wr_mod && wr_hi_lane)
            mod_buf_r[14:8] <= avs_writedata_in[14:8];
         if (wr_dtm && wr_lo_lane)
            dtm_r[7:0] <= avs_writedata_in[7:0];
         if (wr_dtm && wr_hi_lane)
            dtm_r[11:8] <= avs_writedata_in[11:8];
         if (wr_en && wr_lo_lane)
         begin
            // global select is frozen by the same lock as deadtime
            if (!write_protect_in)
               gsel_r <= avs_writedata_in[`EN_GLOBAL_SEL_BIT];
            irq_en_r <= avs_writedata_in[`EN_IRQ_EN_BIT];
         end
      end
   end

   // ---------------------------------------------------------------
   // reload flag and load-okay handshakes
   // ---------------------------------------------------------------
   // the armed bit records a read that saw the flag set; a reload in between
   // disarms it, so a late write of one cannot lose the newer reload
   always @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         flag_r       <= 1'b0;
         flag_armed_r <= 1'b0;
      end
      else
      begin
         if (reload)
         begin
            flag_r       <= 1'b1;
            flag_armed_r <= 1'b0;
         end
         else
         begin
            if (wr_fq && wr_lo_lane && avs_writedata_in[`FQ_FLAG_BIT] && flag_armed_r)
               flag_r <= 1'b0;
            if (rd_acc && hit(avs_address_in, `OFS_FREQ_CTRL) && multi_generator_enable_in)
               flag_armed_r <= flag_r;
            else if (wr_fq)
               flag_armed_r <= 1'b0;
         end
      end
   end

   always @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ldok_r       <= 1'b0;
         ldok_armed_r <= 1'b0;
      end
      else
      begin
         if (reload && ldok_r)
            ldok_r <= 1'b0;
         else if (wr_en && wr_lo_lane)
         begin
            if (!avs_writedata_in[`EN_LDOK_BIT])
               ldok_r <= 1'b0;
            else if (ldok_armed_r)
               ldok_r <= 1'b1;
         end
         if (rd_acc && hit(avs_address_in, `OFS_ENABLE_CTRL) && multi_generator_enable_in)
            ldok_armed_r <= ~ldok_r;
         else if (wr_en)
            ldok_armed_r <= 1'b0;
      end
   end

   assign reload_irq_out = flag_r & irq_en_r;
   assign reload_pulse_out     = reload;
   assign prescaler_active_out = prsc_act_r;
   assign modulus_active_out   = mod_act_r;

   // deadtime is kept in pwm clocks, so its length in core clocks follows the
   // active prescaler divisor without a multiplier here
   always @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         deadtime_ticks_out <= `RST_DEADTIME;
      else
         deadtime_ticks_out <= dtm_r;
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         avs_readdata_out <= `DATA_ZERO;
      else if (!multi_generator_enable_in)
         avs_readdata_out <= `DATA_ZERO;
      else if (avs_read_in && avs_waitrequest_out)
      begin
         case (avs_address_in)
            `OFS_FREQ_CTRL:
               avs_readdata_out <= {24'h00_0000, ldfq_buf_r, half_r, prsc_buf_r, flag_r};
            `OFS_COUNTER:
               avs_readdata_out <= {17'h0_0000, counter_out};
            `OFS_MODULUS:
               avs_readdata_out <= {17'h0_0000, mod_buf_r};
            `OFS_DEADTIME:
               avs_readdata_out <= {20'h0_0000, dtm_r};
            `OFS_ENABLE_CTRL:
               avs_readdata_out <= {29'h0000_0000, gsel_r, ldok_r, irq_en_r};
            default:
               avs_readdata_out <= `DATA_ZERO;
         endcase
      end
   end
endmodule // pwm_gen_c_reload_timing

// [rtl/pwm_c_regs.vh]
// register offsets, field positions and reset values for generator c timing control
// assumes a 32-bit avalon-mm slave with one register per aligned word
`ifndef PWM_C_REGS_VH
`define PWM_C_REGS_VH

`define OFS_FREQ_CTRL      5'h00
`define OFS_COUNTER        5'h04
`define OFS_MODULUS        5'h08
`define OFS_DEADTIME       5'h0C
`define OFS_ENABLE_CTRL    5'h10

`define FQ_LDFQ_HI         7
`define FQ_LDFQ_LO         4
`define FQ_HALF_BIT        3
`define FQ_PRSC_HI         2
`define FQ_PRSC_LO         1
`define FQ_FLAG_BIT        0

`define EN_GLOBAL_SEL_BIT  2
`define EN_LDOK_BIT        1
`define EN_IRQ_EN_BIT      0

`define RST_DEADTIME       12'h0FFF
`define RST_MODULUS        15'h0001
`define MOD_ZERO           15'h0000
`define MOD_ONE            15'h0001
`define DATA_ZERO          32'h0000_0000

`endif

// [rtl/pwm_c_prescaler.v]
// prescaler for generator c: emits one-cycle pwm clock ticks
// assumes sel is stable between reloads; counter restarts on restart_in
`timescale 1ns/10ps
module pwm_c_prescaler
(
   input  wire       core_clk_in,
   input  wire       arst_n_in,
   input  wire       restart_in,
   input  wire [1:0] sel_in,
   output wire       tick_out
);
   reg  [2:0] div_cnt_r;
   wire [2:0] div_max;

   // divide by 1, 2, 4 or 8
   assign div_max  = (3'h1 << sel_in) - 3'h1;
   assign tick_out = (div_cnt_r == div_max);

   always @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         div_cnt_r <= 3'h0;
      else if (restart_in || tick_out)
         div_cnt_r <= 3'h0;
      else
         div_cnt_r <= div_cnt_r + 3'h1;
   end
endmodule // pwm_c_prescaler

// [test/pwm_c_timing_asserts.sv]
// concurrent checks on the generator c timing block, seen from its ports only
// assumes requests and unit inputs change just after the rising clock edge
`timescale 1ns/10ps
module pwm_c_timing_asserts
(
   input wire logic        core_clk_in,
   input wire logic        arst_n_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        multi_generator_enable_in,
   input wire logic        write_protect_in,
   input wire logic        center_aligned_in,
   input wire logic        reload_irq_out,
   input wire logic        reload_pulse_out,
   input wire logic [14:0] counter_out,
   input wire logic [11:0] deadtime_ticks_out,
   input wire logic [1:0]  prescaler_active_out,
   input wire logic [14:0] modulus_active_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   // ----------------------------------------
   // bus timing and register gating
   // ----------------------------------------
   a_wait_one_cycle: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("bus answer late");
   a_read_zero_off: assert property (avs_read_in && !avs_waitrequest_out
      && !multi_generator_enable_in && !$past(multi_generator_enable_in)
      |-> avs_readdata_out == 32'h0000_0000) else $error("read not zero while disabled");
   // ----------------------------------------
   // reload timing and buffered values
   // ----------------------------------------
   a_mod_at_reload: assert property ($changed(modulus_active_out)
      |-> $past(reload_pulse_out)) else $error("modulus changed off reload");
   a_prsc_at_reload: assert property ($changed(prescaler_active_out)
      |-> $past(reload_pulse_out)) else $error("prescaler changed off reload");
   a_pulse_at_turn: assert property (reload_pulse_out |-> counter_out == 15'h0000
      || center_aligned_in && counter_out == modulus_active_out)
      else $error("reload away from count zero or top");
   a_count_in_range: assert property (counter_out <= modulus_active_out)
      else $error("counter beyond modulus");
   a_irq_from_flag: assert property ($rose(reload_irq_out)
      |-> $past(reload_pulse_out) || $past(avs_write_in)) else $error("irq rose without cause");
   a_irq_drop_write: assert property ($fell(reload_irq_out) |-> $past(avs_write_in))
      else $error("irq dropped without a write");
   a_dead_locked: assert property ($past(write_protect_in, 2) && $past(write_protect_in)
      |-> $stable(deadtime_ticks_out)) else $error("deadtime changed while locked");
   a_dead_by_write: assert property ($changed(deadtime_ticks_out)
      |-> $past(avs_write_in) || $past(avs_write_in, 2)) else $error("deadtime changed alone");
endmodule // pwm_c_timing_asserts

bind pwm_gen_c_reload_timing pwm_c_timing_asserts i_chk (.*);

// [test/pwm_gen_c_reload_timing_tb.sv]
// self-checking bench for the generator c timing block, one scenario task each
// assumes one 10 MHz clock and a one-wait-state avalon-mm slave
`timescale 1ns/10ps
`include "pwm_c_regs.vh"
module pwm_gen_c_reload_timing_tb;
   logic        core_clk_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic [4:0]  avs_address_in = 5'h00;
   logic        avs_read_in = 1'b0;
   logic        avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0000_0000;
   logic [3:0]  avs_byteenable_in = 4'hf;
   logic        multi_generator_enable_in = 1'b0;
   logic        write_protect_in = 1'b0;
   logic        global_load_okay_in = 1'b0;
   logic        center_aligned_in = 1'b0;
   wire  [31:0] avs_readdata_out;
   wire         avs_waitrequest_out;
   wire         reload_irq_out;
   wire         reload_pulse_out;
   wire  [14:0] counter_out;
   wire  [11:0] deadtime_ticks_out;
   wire  [1:0]  prescaler_active_out;
   wire  [14:0] modulus_active_out;
   integer      mismatches = 0;
   integer      total_checks = 0;
   integer      n;
   logic [31:0] q;

   pwm_gen_c_reload_timing i_dut (.*);

   always #50 core_clk_in = ~core_clk_in;

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task results;
      begin
         $display("checks %0d mismatches %0d", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask

   task cmp(input logic [31:0] got, input logic [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp)
         begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // one request held until waitrequest is sampled low, then one idle edge
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      integer k;
      begin
         avs_write_in <= w;
         avs_read_in <= !w;
         avs_address_in <= a;
         avs_writedata_in <= d;
         k = 0;
         @(posedge core_clk_in);
         while (avs_waitrequest_out !== 1'b0)
         begin
            k = k + 1;
            if (k > 20)
            begin
               mismatches = mismatches + 1;
               results;
            end
            @(posedge core_clk_in);
         end
         q = avs_readdata_out;
         avs_read_in <= 1'b0;
         avs_write_in <= 1'b0;
         @(posedge core_clk_in);
      end
   endtask

   task rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      begin
         bus(1'b0, a, 32'h0000_0000);
         cmp(q & m, e);
      end
   endtask

   // n ends as the edge count from entry up to the next reload pulse
   task pulse;
      begin
         n = 1;
         @(posedge core_clk_in);
         while (reload_pulse_out !== 1'b1)
         begin
            n = n + 1;
            if (n > 3000)
            begin
               mismatches = mismatches + 1;
               results;
            end
            @(posedge core_clk_in);
         end
      end
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_gate;
      begin
         cmp(deadtime_ticks_out, 32'h0000_0fff);
         bus(1'b1, `OFS_MODULUS, 32'h0000_0007);
         rd(`OFS_MODULUS, 32'hffff_ffff, 32'h0000_0000);
         rd(`OFS_DEADTIME, 32'hffff_ffff, 32'h0000_0000);
         multi_generator_enable_in <= 1'b1;
         @(posedge core_clk_in);
         rd(`OFS_MODULUS, 32'h0000_7fff, 32'h0000_0001);
      end
   endtask

   task t_load;
      begin
         bus(1'b1, `OFS_MODULUS, 32'h0000_0005);
         bus(1'b1, `OFS_COUNTER, 32'h0000_0055);
         rd(`OFS_MODULUS, 32'h0000_7fff, 32'h0000_0005);
         bus(1'b1, `OFS_FREQ_CTRL, 32'h0000_0006);
         rd(`OFS_FREQ_CTRL, 32'h0000_00fe, 32'h0000_0006);
         cmp(modulus_active_out, 32'h0000_0001);
         rd(`OFS_ENABLE_CTRL, 32'h0000_0002, 32'h0000_0000);
         bus(1'b1, `OFS_ENABLE_CTRL, 32'h0000_0002);
         pulse;
         repeat (2) @(posedge core_clk_in);
         cmp(modulus_active_out, 32'h0000_0005);
         cmp(prescaler_active_out, 32'h0000_0003);
         rd(`OFS_ENABLE_CTRL, 32'h0000_0002, 32'h0000_0000);
         pulse;
         pulse;
         cmp(n, 32'd40);
      end
   endtask

   task t_ldfq;
      begin
         bus(1'b1, `OFS_FREQ_CTRL, 32'h0000_0036);
         rd(`OFS_FREQ_CTRL, 32'h0000_00fe, 32'h0000_0036);
         pulse;
         pulse;
         cmp(n, 32'd160);
      end
   endtask

   // a write without the arming read, and one after a reload, must leave the flag
   task t_flag;
      begin
         bus(1'b1, `OFS_ENABLE_CTRL, 32'h0000_0001);
         cmp(reload_irq_out, 32'h0000_0001);
         bus(1'b1, `OFS_FREQ_CTRL, 32'h0000_0037);
         rd(`OFS_FREQ_CTRL, 32'h0000_0001, 32'h0000_0001);
         pulse;
         bus(1'b1, `OFS_FREQ_CTRL, 32'h0000_0037);
         rd(`OFS_FREQ_CTRL, 32'h0000_0001, 32'h0000_0001);
         bus(1'b1, `OFS_FREQ_CTRL, 32'h0000_0037);
         rd(`OFS_FREQ_CTRL, 32'h0000_0001, 32'h0000_0000);
         cmp(reload_irq_out, 32'h0000_0000);
         bus(1'b1, `OFS_ENABLE_CTRL, 32'h0000_0000);
         pulse;
         repeat (2) @(posedge core_clk_in);
         cmp(reload_irq_out, 32'h0000_0000);
         rd(`OFS_FREQ_CTRL, 32'h0000_0001, 32'h0000_0001);
      end
   endtask

   task t_global;
      begin
         bus(1'b1, `OFS_FREQ_CTRL, 32'h0000_0030);
         pulse;
         repeat (2) @(posedge core_clk_in);
         cmp(prescaler_active_out, 32'h0000_0003);
         bus(1'b1, `OFS_ENABLE_CTRL, 32'h0000_0004);
         global_load_okay_in <= 1'b1;
         pulse;
         global_load_okay_in <= 1'b0;
         repeat (2) @(posedge core_clk_in);
         cmp(prescaler_active_out, 32'h0000_0000);
      end
   endtask

   task t_dead;
      begin
         bus(1'b1, `OFS_DEADTIME, 32'h0000_0123);
         repeat (2) @(posedge core_clk_in);
         cmp(deadtime_ticks_out, 32'h0000_0123);
         write_protect_in <= 1'b1;
         @(posedge core_clk_in);
         bus(1'b1, `OFS_DEADTIME, 32'h0000_0456);
         rd(`OFS_DEADTIME, 32'h0000_0fff, 32'h0000_0123);
         cmp(deadtime_ticks_out, 32'h0000_0123);
      end
   endtask

   // center-aligned modulus 5 gives a turn every 5 ticks once half reloads are on
   task t_half;
      begin
         center_aligned_in <= 1'b1;
         bus(1'b1, `OFS_FREQ_CTRL, 32'h0000_0008);
         pulse;
         pulse;
         pulse;
         pulse;
         cmp(n, 32'd5);
      end
   endtask

   initial
   begin
      repeat (12) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      @(posedge core_clk_in);
      t_gate;
      t_load;
      t_ldfq;
      t_flag;
      t_global;
      t_dead;
      t_half;
      results;
   end
endmodule // pwm_gen_c_reload_timing_tb
